/* pkg/ops_regs.svh */
`ifndef OPS_REGS_SVH
`define OPS_REGS_SVH
// Sequence timing
`define OPS_SEQ_TIME_S 20
`define OPS_CLK_HZ 125000000
// 20 s at 125 MHz, written out: the product overflows a signed int
`define OPS_SEQ_CYCLES 32'h9502_F900
// Switch debounce time in microseconds
`define OPS_DEB_TIME_US 1000
`define OPS_DEB_CYCLES (`OPS_DEB_TIME_US * (`OPS_CLK_HZ / 1000000))
// Unit address plug codes
`define OPS_ADDR_SERVICE 4'h8
`define OPS_ADDR_NONE 4'hF
`define OPS_PANEL_W 4
`endif

/* pkg/ops_pkg.sv */
`default_nettype none
package ops_pkg;
    typedef enum logic [2:0] {
        OPS_IDLE = 3'b000,
        OPS_SPINUP = 3'b001,
        OPS_HEADLOAD = 3'b011,
        OPS_READY = 3'b010,
        OPS_RETRACT = 3'b110,
        OPS_BRAKE = 3'b111
    } ops_state_t;
endpackage : ops_pkg
`default_nettype wire

/* pkg/ops_sw_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Raw and debounced panel switches
interface ops_sw_if;
    logic [3:0] raw;
    logic [3:0] clean;
    modport deb (input raw, output clean);
    modport seq (output raw, input clean);
endinterface : ops_sw_if
`default_nettype wire

/* hw/ops_debounce.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ops_regs.svh"
module ops_debounce #(
    parameter int W = 4,
    parameter int CNT = `OPS_DEB_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    ops_sw_if.deb sw
);
    import ops_pkg::*;
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] clean;
        logic [W-1:0] cand;
        logic [16:0] cnt;
    } ops_deb_t;
    ops_deb_t q, next_q;
    // Two-flop sync, then hold a changed value CNT cycles before accepting
    always_comb begin
        next_q = q;
        next_q.s1 = sw.raw;
        next_q.s2 = q.s1;
        if (q.s2 != q.cand) begin
            next_q.cand = q.s2;
            next_q.cnt = '0;
        end else if (q.cand != q.clean) begin
            if (q.cnt >= 17'(CNT - 1)) begin
                next_q.clean = q.cand;
            end else begin
                next_q.cnt = q.cnt + 17'h0001;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
    assign sw.clean = q.clean;
    a_deb_stable: assert property (@(posedge core_clk)
        disable iff (!rst_n) $changed(q.clean) |-> $past(q.cand) == q.clean)
        else $error("debounced output took unstable value");
endmodule : ops_debounce
`default_nettype wire

/* hw/ops_panel.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ops_regs.svh"
module ops_panel #(
    parameter int unsigned SEQ_CYCLES = `OPS_SEQ_CYCLES,
    parameter int DEB_CYCLES = `OPS_DEB_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sw_start,
    input wire logic sw_stop,
    input wire logic sw_wprot,
    input wire logic sw_lamp_test,
    input wire logic sw_port_a,
    input wire logic sw_port_b,
    input wire logic door_closed,
    input wire logic interlocks_ok,
    input wire logic at_speed,
    input wire logic spindle_stopped,
    input wire logic heads_retracted,
    input wire logic seq_fault,
    input wire logic rw_safety_err,
    input wire logic standby_cmd,
    input wire logic port_a_lamp,
    input wire logic port_b_lamp,
    input wire logic read_cmd,
    input wire logic write_cmd,
    input wire logic writing,
    input wire logic [3:0] unit_address_plug,
    output logic door_lock,
    output logic spindle_run,
    output logic brake,
    output logic heads_load,
    output logic carriage_reverse,
    output logic head_select,
    output logic read_enable,
    output logic write_enable,
    output logic port_a_locked,
    output logic port_b_locked,
    output logic lamp_start,
    output logic lamp_ready,
    output logic lamp_unsafe,
    output logic lamp_standby,
    output logic lamp_wprot,
    output logic lamp_door,
    output logic lamp_port_a,
    output logic lamp_port_b,
    output logic [3:0] unit_addr,
    output logic unit_service,
    output logic unit_valid
);
    import ops_pkg::*;
    ops_sw_if sw ();
    assign sw.raw = {sw_lamp_test, sw_wprot, sw_stop, sw_start};
    // The start, stop, protect and lamp-test switches pass a filter before the sequencer sees them
    ops_debounce #(.W(`OPS_PANEL_W), .CNT(DEB_CYCLES)) u_deb (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sw(sw.deb)
    );
    logic c_start, c_stop, c_wprot, c_ltest;
    assign {c_ltest, c_wprot, c_stop, c_start} = sw.clean;

    typedef struct packed {
        ops_state_t st;
        logic [31:0] tmr;
        logic start_d;
        logic pwr_up;
        logic unsafe;
        logic standby;
        logic wp_eff;
        logic lock;
        logic run;
        logic brk;
        logic load;
        logic rev;
        logic hsel;
        logic rd_en;
        logic wr_en;
        logic pa;
        logic pb;
        logic l_start;
        logic l_ready;
        logic l_unsafe;
        logic l_standby;
        logic l_wprot;
        logic l_door;
        logic l_pa;
        logic l_pb;
        logic l_start_o;
        logic [3:0] addr;
        logic svc;
        logic addr_ok;
    } ops_panel_t;
    ops_panel_t q, next_q;

    logic start_press, start_ok, go, stop_req, abn, settled;
    // Timer limit check is shared by the start and stop sequences
    function automatic logic tmr_expired(input logic [31:0] t);
        return t >= 32'(SEQ_CYCLES - 1);
    endfunction : tmr_expired

    assign start_press = c_start && !q.start_d;
    assign start_ok = door_closed && interlocks_ok && !c_stop;

    always_comb begin
        next_q = q;
        next_q.start_d = c_start;
        go = 1'b0;
        settled = 1'b0;
        stop_req = c_stop || standby_cmd || !door_closed;
        abn = 1'b0;
        // Start press clears standby and unsafe when conditions hold
        if (start_press && start_ok && !standby_cmd) begin
            next_q.standby = 1'b0;
            next_q.unsafe = 1'b0;
        end
        unique case (q.st)
            OPS_IDLE: begin
                // Mains restore waits for the switch filter to settle, so
                // a switch held at stop is seen before any spin-up
                settled = q.tmr >= 32'(DEB_CYCLES + 3);
                if (q.pwr_up) begin
                    next_q.tmr = q.tmr + 32'h0000_0001;
                    next_q.pwr_up = !settled;
                end
                // A standing safety error keeps unsafe set, so no restart
                go = start_ok && !standby_cmd && (
                    (start_press && !rw_safety_err)
                    || (q.pwr_up && settled && !c_start && !q.unsafe));
                if (go) begin
                    next_q.st = OPS_SPINUP;
                    next_q.lock = 1'b1;
                    next_q.l_start = 1'b1;
                    next_q.tmr = '0;
                    next_q.pwr_up = 1'b0;
                end
            end
            OPS_SPINUP: begin
                next_q.tmr = q.tmr + 32'h0000_0001;
                next_q.run = q.lock && door_closed;
                if (stop_req) begin
                    next_q.st = OPS_RETRACT;
                end else if (seq_fault || tmr_expired(q.tmr)) begin
                    abn = 1'b1;
                    next_q.st = OPS_RETRACT;
                end else if (at_speed) begin
                    next_q.st = OPS_HEADLOAD;
                end
            end
            OPS_HEADLOAD: begin
                next_q.load = 1'b1;
                next_q.tmr = q.tmr + 32'h0000_0001;
                if (stop_req) begin
                    next_q.st = OPS_RETRACT;
                end else if (seq_fault || tmr_expired(q.tmr)) begin
                    abn = 1'b1;
                    next_q.st = OPS_RETRACT;
                end else if (!heads_retracted) begin
                    next_q.st = OPS_READY;
                end
            end
            OPS_READY: begin
                if (stop_req || seq_fault) begin
                    abn = seq_fault;
                    next_q.st = OPS_RETRACT;
                end
            end
            OPS_RETRACT: begin
                next_q.load = 1'b0;
                next_q.rev = 1'b1;
                if (heads_retracted) begin
                    next_q.st = OPS_BRAKE;
                    next_q.tmr = '0;
                end
            end
            OPS_BRAKE: begin
                next_q.rev = 1'b0;
                next_q.run = 1'b0;
                next_q.brk = 1'b1;
                next_q.tmr = q.tmr + 32'h0000_0001;
                // Door unlocks once rotation has stopped or the brake timer expires
                if (spindle_stopped || tmr_expired(q.tmr)) begin
                    next_q.st = OPS_IDLE;
                    next_q.brk = 1'b0;
                    next_q.lock = 1'b0;
                end
            end
            default: next_q.st = OPS_IDLE;
        endcase
        // Any stop drops start and ready lamps at once
        if (q.st != OPS_IDLE && (stop_req || abn)) begin
            next_q.l_start = 1'b0;
        end
        if (standby_cmd && q.st != OPS_IDLE) begin
            next_q.standby = 1'b1;
        end
        if (abn || rw_safety_err) begin
            next_q.unsafe = 1'b1;
        end
        // Protect latches only when no write runs
        if (!writing) begin
            next_q.wp_eff = c_wprot;
        end
        next_q.hsel = q.st == OPS_READY && !(read_cmd && write_cmd);
        next_q.rd_en = next_q.hsel && read_cmd;
        next_q.wr_en = next_q.hsel && write_cmd && !next_q.wp_eff;
        next_q.pa = sw_port_a && !sw_port_b;
        next_q.pb = sw_port_b && !sw_port_a;
        next_q.addr = unit_address_plug;
        next_q.svc = unit_address_plug == `OPS_ADDR_SERVICE;
        next_q.addr_ok = unit_address_plug <= `OPS_ADDR_SERVICE;
        // Lamp test overrides every indicator
        next_q.l_ready = c_ltest
            || (next_q.st == OPS_READY && !stop_req);
        next_q.l_start_o = c_ltest || next_q.l_start;
        next_q.l_unsafe = c_ltest || next_q.unsafe;
        next_q.l_standby = c_ltest || next_q.standby;
        next_q.l_wprot = c_ltest || c_wprot;
        next_q.l_door = c_ltest || next_q.lock;
        next_q.l_pa = c_ltest || port_a_lamp;
        next_q.l_pb = c_ltest || port_b_lamp;
    end

    // Reset state marks the next idle spell as a mains restore
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.pwr_up <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign door_lock = q.lock;
    assign spindle_run = q.run;
    assign brake = q.brk;
    assign heads_load = q.load;
    assign carriage_reverse = q.rev;
    assign head_select = q.hsel;
    assign read_enable = q.rd_en;
    assign write_enable = q.wr_en;
    assign port_a_locked = q.pa;
    assign port_b_locked = q.pb;
    assign lamp_start = q.l_start_o;
    assign lamp_ready = q.l_ready;
    assign lamp_unsafe = q.l_unsafe;
    assign lamp_standby = q.l_standby;
    assign lamp_wprot = q.l_wprot;
    assign lamp_door = q.l_door;
    assign lamp_port_a = q.l_pa;
    assign lamp_port_b = q.l_pb;
    assign unit_addr = q.addr;
    assign unit_service = q.svc;
    assign unit_valid = q.addr_ok;

    // Checks on the sequencer, all in the one clock domain
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_run_locked: assert property (spindle_run |-> door_lock)
        else $error("spindle runs with door unlocked");
    a_load_speed: assert property ($rose(heads_load)
        |-> $past(at_speed, 2))
        else $error("heads loaded before speed");
    a_rw_conflict: assert property ((read_cmd && write_cmd)
        |=> !read_enable && !write_enable)
        else $error("read and write both enabled");
    a_wp_block: assert property (c_wprot && !writing
        && $past(c_wprot) |=> !write_enable)
        else $error("write allowed under protect");
    a_port_lock: assert property ((!sw_port_a && !sw_port_b)
        |=> !port_a_locked && !port_b_locked)
        else $error("port lock set in centre");
    a_lamp_test: assert property (c_ltest
        |=> lamp_ready && lamp_unsafe && lamp_door && lamp_start
        && lamp_standby && lamp_wprot && lamp_port_a && lamp_port_b)
        else $error("lamp test incomplete");
    a_wp_lamp: assert property (c_wprot |=> lamp_wprot)
        else $error("write-protect lamp off");
    a_unsafe_set: assert property (rw_safety_err |=> lamp_unsafe)
        else $error("unsafe lamp missing");
    a_stop_ready: assert property ((c_stop && !c_ltest)
        |=> !lamp_ready)
        else $error("ready stays lit on stop");
    a_ready_lamp: assert property (!$past(c_ltest)
        |-> lamp_ready == (q.st == OPS_READY))
        else $error("ready lamp differs from on-line state");
    a_door_lamp: assert property (!$past(c_ltest)
        |-> lamp_door == door_lock)
        else $error("door lamp differs from door lock");
    a_standby_lamp: assert property (standby_cmd && q.st != OPS_IDLE
        |=> lamp_standby)
        else $error("standby lamp missing");
    a_seq_bound: assert property (
        (q.st == OPS_SPINUP || q.st == OPS_HEADLOAD)
        |-> q.tmr < 32'(SEQ_CYCLES))
        else $error("start sequence ran past its time");
    c_reach_ready: cover property (@(posedge core_clk) q.st == OPS_READY);
    c_standby: cover property (@(posedge core_clk) $rose(lamp_standby));
    c_abnormal: cover property (@(posedge core_clk) $rose(q.unsafe));
endmodule : ops_panel
`default_nettype wire

/* verif/ops_drive_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Spindle and carriage mechanics behind the panel logic
module ops_drive_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic spindle_run,
    input wire logic brake,
    input wire logic heads_load,
    output logic at_speed,
    output logic spindle_stopped,
    output logic heads_retracted
);
    logic [3:0] spd;
    logic [1:0] hpos;
    // Slow ramps, so each sequencer wait state spans several cycles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            spd <= 4'h0;
            hpos <= 2'h0;
        end else begin
            if (spindle_run && !brake && spd != 4'hA) begin
                spd <= spd + 4'h1;
            end else if ((brake || !spindle_run) && spd != 4'h0) begin
                spd <= spd - 4'h1;
            end
            if (heads_load && hpos != 2'h3) begin
                hpos <= hpos + 2'h1;
            end else if (!heads_load && hpos != 2'h0) begin
                hpos <= hpos - 2'h1;
            end
        end
    end
    // Status levels derived from the ramps
    assign at_speed = (spd == 4'hA);
    assign spindle_stopped = (spd == 4'h0);
    assign heads_retracted = (hpos == 2'h0);
endmodule : ops_drive_model
`default_nettype wire

/* verif/test_operator_panel_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module test_operator_panel_sequencer;
    logic core_clk, rst_n, sw_start, sw_stop, sw_wprot, sw_lamp_test;
    logic sw_port_a, sw_port_b, door_closed, interlocks_ok, seq_fault;
    logic rw_safety_err, standby_cmd, port_a_lamp, port_b_lamp;
    logic read_cmd, write_cmd, writing;
    logic [3:0] unit_address_plug, unit_addr;
    logic at_speed, spindle_stopped, heads_retracted, door_lock;
    logic spindle_run, brake, heads_load, head_select, read_enable;
    logic write_enable, port_a_locked, port_b_locked, lamp_start;
    logic lamp_ready, lamp_unsafe, lamp_standby, lamp_wprot, lamp_door;
    logic lamp_port_a, lamp_port_b, unit_service, unit_valid;
    logic carriage_reverse;
    int num_errors = 0;
    int n_checks = 0;

    // Short counts keep the run small
    ops_panel #(.SEQ_CYCLES(100), .DEB_CYCLES(4)) ops_panel_i (
        .core_clk(core_clk), .rst_n(rst_n), .sw_start(sw_start),
        .sw_stop(sw_stop), .sw_wprot(sw_wprot),
        .sw_lamp_test(sw_lamp_test), .sw_port_a(sw_port_a),
        .sw_port_b(sw_port_b), .door_closed(door_closed),
        .interlocks_ok(interlocks_ok), .at_speed(at_speed),
        .spindle_stopped(spindle_stopped),
        .heads_retracted(heads_retracted), .seq_fault(seq_fault),
        .rw_safety_err(rw_safety_err), .standby_cmd(standby_cmd),
        .port_a_lamp(port_a_lamp), .port_b_lamp(port_b_lamp),
        .read_cmd(read_cmd), .write_cmd(write_cmd), .writing(writing),
        .unit_address_plug(unit_address_plug), .door_lock(door_lock),
        .spindle_run(spindle_run), .brake(brake), .heads_load(heads_load),
        .carriage_reverse(carriage_reverse), .head_select(head_select),
        .read_enable(read_enable), .write_enable(write_enable),
        .port_a_locked(port_a_locked), .port_b_locked(port_b_locked),
        .lamp_start(lamp_start), .lamp_ready(lamp_ready),
        .lamp_unsafe(lamp_unsafe), .lamp_standby(lamp_standby),
        .lamp_wprot(lamp_wprot), .lamp_door(lamp_door),
        .lamp_port_a(lamp_port_a), .lamp_port_b(lamp_port_b),
        .unit_addr(unit_addr), .unit_service(unit_service),
        .unit_valid(unit_valid));

    ops_drive_model ops_drive_model_i (
        .core_clk(core_clk), .rst_n(rst_n), .spindle_run(spindle_run),
        .brake(brake), .heads_load(heads_load), .at_speed(at_speed),
        .spindle_stopped(spindle_stopped),
        .heads_retracted(heads_retracted));

    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wt

    function automatic logic sel(input int k);
        case (k)
            0: sel = lamp_ready;
            1: sel = lamp_door;
            2: sel = lamp_start;
            3: sel = lamp_standby;
            5: sel = carriage_reverse;
            6: sel = brake;
            default: sel = lamp_unsafe;
        endcase
    endfunction : sel

    // Bounded wait on a lamp, carriage_reverse or brake, then judge it
    task automatic ws(input int k, input logic v);
        int n;
        n = 0;
        while (sel(k) !== v && n < 1000) begin
            @(posedge core_clk);
            n++;
        end
        chk(sel(k), v);
    endtask : ws

    // Momentary start press, long enough to pass the debouncer
    task automatic press;
        sw_start <= 1'b1;
        wt(12);
        sw_start <= 1'b0;
        wt(12);
    endtask : press

    // Heads must never load before speed; spin only when locked
    always @(posedge core_clk) begin
        if (rst_n && $rose(heads_load)) chk(at_speed, 1'b1);
        if (rst_n && $rose(spindle_run)) chk(door_lock, 1'b1);
    end

    task automatic t_restore;
        ws(2, 1'b1);
        chk(door_lock, 1'b1);
        ws(0, 1'b1);
    endtask : t_restore

    task automatic t_write;
        write_cmd <= 1'b1;
        writing <= 1'b1;
        wt(3);
        chk(write_enable, 1'b1);
        sw_wprot <= 1'b1;
        wt(12);
        chk(lamp_wprot, 1'b1);
        chk(write_enable, 1'b1);
        writing <= 1'b0;
        wt(3);
        chk(write_enable, 1'b0);
        sw_wprot <= 1'b0;
        read_cmd <= 1'b1;
        wt(12);
        chk({head_select, read_enable, write_enable}, 4'h0);
        write_cmd <= 1'b0;
        wt(3);
        chk({head_select, read_enable}, 4'h3);
        read_cmd <= 1'b0;
    endtask : t_write

    task automatic t_panel;
        // Both positions at once reads as centre on the lock lines
        for (int i = 0; i < 4; i++) begin
            {sw_port_a, sw_port_b} <= i[1:0];
            {port_a_lamp, port_b_lamp} <= i[1:0];
            wt(4);
            chk({port_a_locked, port_b_locked},
                (i == 3) ? 4'h0 : 4'(i));
            chk({lamp_port_a, lamp_port_b}, i[1:0]);
        end
        // Codes above the service plug read as absent
        for (int i = 0; i < 10; i++) begin
            unit_address_plug <= i[3:0];
            wt(3);
            chk({unit_valid, unit_service}, {i < 9, i == 8});
            if (i < 8) chk(unit_addr, i[3:0]);
        end
        sw_lamp_test <= 1'b1;
        wt(12);
        chk({lamp_start, lamp_ready, lamp_unsafe, lamp_standby}, 4'hF);
        chk({lamp_wprot, lamp_door, lamp_port_a, lamp_port_b}, 4'hF);
        sw_lamp_test <= 1'b0;
        wt(12);
    endtask : t_panel

    task automatic t_door;
        door_closed <= 1'b0;
        ws(0, 1'b0);
        ws(1, 1'b0);
        door_closed <= 1'b1;
        wt(2);
        press;
        ws(0, 1'b1);
    endtask : t_door

    task automatic t_standby;
        standby_cmd <= 1'b1;
        ws(3, 1'b1);
        ws(1, 1'b0);
        chk({lamp_start, lamp_ready}, 4'h0);
        standby_cmd <= 1'b0;
        wt(2);
        press;
        chk(lamp_standby, 1'b0);
        ws(0, 1'b1);
    endtask : t_standby

    task automatic t_stop;
        sw_stop <= 1'b1;
        wt(9);
        chk({lamp_ready, lamp_start, lamp_door}, 4'h1);
        ws(5, 1'b1);
        chk(heads_load, 1'b0);
        ws(6, 1'b1);
        chk(carriage_reverse, 1'b0);
        ws(1, 1'b0);
        chk({spindle_stopped, door_lock}, 4'h2);
        sw_stop <= 1'b0;
        wt(12);
    endtask : t_stop

    task automatic t_fault;
        seq_fault <= 1'b1;
        press;
        ws(4, 1'b1);
        ws(1, 1'b0);
        seq_fault <= 1'b0;
        wt(2);
        press;
        ws(4, 1'b0);
        ws(0, 1'b1);
        rw_safety_err <= 1'b1;
        ws(4, 1'b1);
    endtask : t_fault

    // Main sequence; switches centred and door shut at power-up
    initial begin
        rst_n <= 1'b0;
        {sw_start, sw_stop, sw_wprot, sw_lamp_test} <= 4'h0;
        {sw_port_a, sw_port_b, port_a_lamp, port_b_lamp} <= 4'h0;
        {door_closed, interlocks_ok, seq_fault, rw_safety_err} <= 4'hC;
        {standby_cmd, read_cmd, write_cmd, writing} <= 4'h0;
        unit_address_plug <= 4'h3;
        wt(5);
        rst_n <= 1'b1;
        t_restore();
        t_write();
        t_panel();
        t_door();
        t_standby();
        t_stop();
        t_fault();
        test_done();
    end

    // Watchdog, well past the expected run length
    initial begin
        wt(60000);
        num_errors++;
        test_done();
    end
endmodule : test_operator_panel_sequencer
`default_nettype wire
